// file: src/tal_pkg.sv
// constants for the tributary alarm fill and line loopback block
// Function
// R1: per port, per path all-ones substitution
// R2: reset forces all-ones, software then releases
// R3: mux disabled makes fill controls irrelevant
// R4: receive bit 0 fills, 1 passes data
// R5: rx low word bit k is port k+1
// R6: rx high word bits 0-11 ports 17-28
// R7: e3 mode ignores ports 17 to 28
// R8: g747 mode ignores ports 4,8,..,28
// R9: transmit bit 0 fills, 1 passes data
// R10: tx words map like receive words
// R11: g747 mode ignores tx ports 22-28
// R12: 28 ports, independent control each path
// R13: per port line loopback rx to tx
// R14: loopback ignores tx clock and data
// R15: loop bits map one per port, 1 enables
// R16: loop 17-28 idle in e3, reset off
// R17: unused high bits read zero, ignore writes
package tal_pkg;
    localparam int unsigned NPORT = 28;      // tributary port count
    localparam int unsigned NLO   = 16;      // ports in a low word
    localparam int unsigned NHI   = 12;      // ports in a high word
    localparam int unsigned AW    = 12;      // apb address width
    localparam int unsigned DW    = 32;      // apb data width
    // register indices; byte address is four times the index
    localparam logic [AW-1:0] IDX_RX_LO = 12'h040;
    localparam logic [AW-1:0] IDX_RX_HI = 12'h042;
    localparam logic [AW-1:0] IDX_TX_LO = 12'h044;
    localparam logic [AW-1:0] IDX_TX_HI = 12'h046;
    localparam logic [AW-1:0] IDX_CTRL  = 12'h048;
    localparam logic [AW-1:0] IDX_RXST  = 12'h04c;
    localparam logic [AW-1:0] IDX_TXST  = 12'h04e;
    localparam logic [AW-1:0] IDX_LL_LO = 12'h050;
    localparam logic [AW-1:0] IDX_LL_HI = 12'h052;
    // control register field positions
    localparam int unsigned CTRL_MUXOFF = 0; // mux_function_disable
    localparam int unsigned CTRL_E3     = 1; // e3 mode, 16 ports
    localparam int unsigned CTRL_G747   = 2; // g747 mode, 16 of ports 1-21
    localparam int unsigned CTRL_W      = 3; // control width
    // reset values
    localparam logic [NLO-1:0]    RST_LO   = 16'h0000;
    localparam logic [NHI-1:0]    RST_HI   = 12'h000;
    localparam logic [CTRL_W-1:0] RST_CTRL = 3'h0;
    // port counts per mode
    localparam int unsigned E3_PORTS   = 16; // active in e3 mode
    localparam int unsigned G747_PORTS = 21; // highest port in g747 mode
    localparam int unsigned G747_GAP   = 4;  // every fourth port idle
endpackage : tal_pkg

// file: src/tal_top.sv
// tributary alarm fill and line loopback with apb register slave
`timescale 1ns/1ps
`default_nettype none
module tal_top (
    input  wire logic                      clk,      // 40 MHz clock
    input  wire logic                      sys_rst,  // sync reset, high
    input  wire logic [tal_pkg::AW-1:0]    paddr,    // apb address
    input  wire logic                      psel,     // apb select
    input  wire logic                      penable,  // apb access phase
    input  wire logic                      pwrite,   // apb write
    input  wire logic [tal_pkg::DW-1:0]    pwdata,   // apb write data
    output logic      [tal_pkg::DW-1:0]    prdata,   // apb read data
    output logic                           pready,   // apb ready
    output logic                           pslverr,  // apb error
    input  wire logic [tal_pkg::NPORT-1:0] demux_rx_data,   // rx bit
    input  wire logic [tal_pkg::NPORT-1:0] demux_rx_strobe, // rx enable
    output logic      [tal_pkg::NPORT-1:0] tributary_rx_data_out,  // rx
    output logic      [tal_pkg::NPORT-1:0] tributary_rx_clock_out, // rx
    input  wire logic [tal_pkg::NPORT-1:0] tributary_tx_data_in,   // tx
    input  wire logic [tal_pkg::NPORT-1:0] tributary_tx_clock_in,  // tx
    output logic      [tal_pkg::NPORT-1:0] mux_tx_data,    // to mux
    output logic      [tal_pkg::NPORT-1:0] mux_tx_strobe   // to mux
);

    // whole block state in one record
    typedef struct packed {
        logic [tal_pkg::NLO-1:0]    rx_lo;   // rx fill, ports 1-16
        logic [tal_pkg::NHI-1:0]    rx_hi;   // rx fill, ports 17-28
        logic [tal_pkg::NLO-1:0]    tx_lo;   // tx fill, ports 1-16
        logic [tal_pkg::NHI-1:0]    tx_hi;   // tx fill, ports 17-28
        logic [tal_pkg::NLO-1:0]    ll_lo;   // loop, ports 1-16
        logic [tal_pkg::NHI-1:0]    ll_hi;   // loop, ports 17-28
        logic [tal_pkg::CTRL_W-1:0] ctrl;    // mode and mux disable
        logic [tal_pkg::DW-1:0]     rdata;   // read data for access
        logic [tal_pkg::NPORT-1:0]  rx_dat;  // rx output data
        logic [tal_pkg::NPORT-1:0]  rx_stb;  // rx output strobe
        logic [tal_pkg::NPORT-1:0]  tx_dat;  // tx output data
        logic [tal_pkg::NPORT-1:0]  tx_stb;  // tx output strobe
        logic [tal_pkg::NPORT-1:0]  rx_fst;  // rx filling now
        logic [tal_pkg::NPORT-1:0]  tx_fst;  // tx filling now
    } tal_state_s;

    tal_state_s st_q;  // registered state
    tal_state_s st_d;  // next state

    // how the block behaves, in short
    //
    // every port has two lanes: a receive lane
    // from the demux to the tributary side, and
    // a transmit lane from the tributary side
    // into the mux
    //
    // each lane is one flop deep; a bit moves
    // only on its own strobe, so the output
    // holds the last bit between strobes
    //
    // fill bits are active low: a zero forces
    // unframed all ones onto the lane, a one
    // lets traffic through
    //
    // reset clears every fill bit, so all
    // lanes carry ones until software writes
    // ones into the fill registers
    //
    // the mux disable bit in the control word
    // turns the fill bits off altogether; the
    // loop bits still apply then
    //
    // the mode bits pick how many ports live:
    //   neither set: all 28 ports
    //   e3 set:      ports 1 to 16
    //   g747 set:    ports 1 to 21, less
    //                every fourth port
    // g747 wins if software sets both bits,
    // so no mix of the two masks can occur
    //
    // an idle port drives ones with no strobe
    // in both lanes, whatever its control bits
    // say; a far end then sees a quiet line
    //
    // line loop takes the raw demux bit and its
    // strobe for the transmit lane; the tx pins
    // of that port are not looked at at all
    //
    // loop data is taken before the rx fill, so
    // a port can fill its rx output and still
    // loop live traffic back toward the mux
    //
    // a tx fill on a looped port still wins
    // and sends ones to the mux
    //
    // hazards and limits
    //
    // the strobes are sampled as plain levels;
    // a strobe held high for many cycles moves
    // a bit on every one of them
    //
    // control writes reach the lanes one edge
    // after the write edge; a bit in flight on
    // that edge still uses the old setting
    //
    // the status words change on the same
    // edge as the lanes, since both register
    // the effective fill vector in one flop
    //
    // register bus
    //
    // the slave never inserts wait states;
    // read data is fetched at the setup edge
    // so the access phase sees a flop output
    //
    // an address outside the map answers with
    // an error and reads zero; a write there
    // changes nothing
    //
    // writes to the status words are dropped
    // without an error, as they hold no state
    //
    // the high words keep twelve bits; the
    // rest read zero and ignore writes
    //
    // trade-off: one flat state record makes
    // reset and next state easy to audit at
    // the cost of a wide always_comb below
    //
    // trade-off: outputs come from flops, so
    // every lane has one cycle of latency but
    // no glitches reach the pins
    //
    // all ports share one clock; the strobes
    // are enables, not clocks, so no domain
    // crossing is needed inside the block
    //

    // ports alive in the chosen mode
    function automatic logic [tal_pkg::NPORT-1:0] active_mask(
        input logic e3,
        input logic g747
    );
        logic [tal_pkg::NPORT-1:0] m;
        m = '1;
        for (int p = 0; p < tal_pkg::NPORT; p++) begin
            if (e3 && (p >= tal_pkg::E3_PORTS)) begin
                m[p] = 1'b0;                                   // R7 R16
            end else if (g747 && (p >= tal_pkg::G747_PORTS)) begin
                m[p] = 1'b0;                                   // R11
            end else if (g747 && (((p + 1) % tal_pkg::G747_GAP) == 0)) begin
                m[p] = 1'b0;                                   // R8
            end
        end
        return m;
    endfunction

    // join the low and high words into one port vector
    function automatic logic [tal_pkg::NPORT-1:0] join_words(
        input logic [tal_pkg::NLO-1:0] lo,
        input logic [tal_pkg::NHI-1:0] hi
    );
        return {hi, lo};                                        // R5 R6 R10 R15
    endfunction

    // decode an apb byte address against a register index
    function automatic logic hit(
        input logic [tal_pkg::AW-1:0] a,
        input logic [tal_pkg::AW-1:0] idx
    );
        return a == {idx[tal_pkg::AW-3:0], 2'b00};
    endfunction

    logic                      act_e3;    // e3 mode selected
    logic                      act_g747;  // g747 mode selected
    logic                      mux_off;   // mux function disabled
    logic [tal_pkg::NPORT-1:0] act;       // active port mask
    logic [tal_pkg::NPORT-1:0] rx_pass;   // rx fill bits, 1 passes
    logic [tal_pkg::NPORT-1:0] tx_pass;   // tx fill bits, 1 passes
    logic [tal_pkg::NPORT-1:0] loop_en;   // line loop bits
    logic [tal_pkg::NPORT-1:0] rx_fill;   // rx all-ones forced
    logic [tal_pkg::NPORT-1:0] tx_fill;   // tx all-ones forced
    logic [tal_pkg::NPORT-1:0] loop_on;   // loop effective
    logic                      mapped;    // address in the map
    logic                      wr_setup;  // write taken this edge
    logic                      rd_setup;  // read prepared this edge

    // mode decode and per-port effective controls
    always_comb begin
        // g747 wins if both mode bits are set
        act_g747 = st_q.ctrl[tal_pkg::CTRL_G747];
        act_e3   = st_q.ctrl[tal_pkg::CTRL_E3] && !act_g747;
        mux_off  = st_q.ctrl[tal_pkg::CTRL_MUXOFF];
        act      = active_mask(act_e3, act_g747);
        rx_pass  = join_words(st_q.rx_lo, st_q.rx_hi);
        tx_pass  = join_words(st_q.tx_lo, st_q.tx_hi);
        loop_en  = join_words(st_q.ll_lo, st_q.ll_hi);
        // fill bits count only with the mux on
        rx_fill  = mux_off ? '0 : (~rx_pass & act);             // R3 R4 R7 R8
        tx_fill  = mux_off ? '0 : (~tx_pass & act);             // R3 R9 R11
        loop_on  = loop_en & act;                               // R15 R16
    end

    // apb decode; the slave never stalls
    always_comb begin
        mapped = hit(paddr, tal_pkg::IDX_RX_LO)
              || hit(paddr, tal_pkg::IDX_RX_HI)
              || hit(paddr, tal_pkg::IDX_TX_LO)
              || hit(paddr, tal_pkg::IDX_TX_HI)
              || hit(paddr, tal_pkg::IDX_CTRL)
              || hit(paddr, tal_pkg::IDX_RXST)
              || hit(paddr, tal_pkg::IDX_TXST)
              || hit(paddr, tal_pkg::IDX_LL_LO)
              || hit(paddr, tal_pkg::IDX_LL_HI);
        wr_setup = psel && penable && pwrite && mapped;
        // read data is fetched in setup so the access sees a flop
        rd_setup = psel && !penable && !pwrite;
    end

    assign pready  = 1'b1;                      // no wait states
    assign pslverr = psel && penable && !mapped;
    assign prdata  = st_q.rdata;

    // next state: register writes, read fetch, data paths
    always_comb begin
        st_d = st_q;
        // writes land at the access edge
        if (wr_setup) begin
            if (hit(paddr, tal_pkg::IDX_RX_LO)) begin
                st_d.rx_lo = pwdata[tal_pkg::NLO-1:0];          // R5
            end else if (hit(paddr, tal_pkg::IDX_RX_HI)) begin
                st_d.rx_hi = pwdata[tal_pkg::NHI-1:0];          // R6 R17
            end else if (hit(paddr, tal_pkg::IDX_TX_LO)) begin
                st_d.tx_lo = pwdata[tal_pkg::NLO-1:0];          // R10
            end else if (hit(paddr, tal_pkg::IDX_TX_HI)) begin
                st_d.tx_hi = pwdata[tal_pkg::NHI-1:0];          // R10 R17
            end else if (hit(paddr, tal_pkg::IDX_CTRL)) begin
                st_d.ctrl = pwdata[tal_pkg::CTRL_W-1:0];
            end else if (hit(paddr, tal_pkg::IDX_LL_LO)) begin
                st_d.ll_lo = pwdata[tal_pkg::NLO-1:0];          // R15
            end else if (hit(paddr, tal_pkg::IDX_LL_HI)) begin
                st_d.ll_hi = pwdata[tal_pkg::NHI-1:0];          // R15
            end
        end
        // read mux; unused upper bits read zero
        if (rd_setup) begin
            st_d.rdata = '0;
            if (hit(paddr, tal_pkg::IDX_RX_LO)) begin
                st_d.rdata[tal_pkg::NLO-1:0] = st_q.rx_lo;
            end else if (hit(paddr, tal_pkg::IDX_RX_HI)) begin
                st_d.rdata[tal_pkg::NHI-1:0] = st_q.rx_hi;      // R17
            end else if (hit(paddr, tal_pkg::IDX_TX_LO)) begin
                st_d.rdata[tal_pkg::NLO-1:0] = st_q.tx_lo;
            end else if (hit(paddr, tal_pkg::IDX_TX_HI)) begin
                st_d.rdata[tal_pkg::NHI-1:0] = st_q.tx_hi;      // R17
            end else if (hit(paddr, tal_pkg::IDX_CTRL)) begin
                st_d.rdata[tal_pkg::CTRL_W-1:0] = st_q.ctrl;
            end else if (hit(paddr, tal_pkg::IDX_RXST)) begin
                st_d.rdata[tal_pkg::NPORT-1:0] = st_q.rx_fst;
            end else if (hit(paddr, tal_pkg::IDX_TXST)) begin
                st_d.rdata[tal_pkg::NPORT-1:0] = st_q.tx_fst;
            end else if (hit(paddr, tal_pkg::IDX_LL_LO)) begin
                st_d.rdata[tal_pkg::NLO-1:0] = st_q.ll_lo;
            end else if (hit(paddr, tal_pkg::IDX_LL_HI)) begin
                st_d.rdata[tal_pkg::NHI-1:0] = st_q.ll_hi;
            end
        end
        // live fill state for software to read back
        st_d.rx_fst = rx_fill;
        st_d.tx_fst = tx_fill;
        // one independent lane per port in each path
        for (int p = 0; p < tal_pkg::NPORT; p++) begin          // R12
            // receive lane: strobe follows the demux
            st_d.rx_stb[p] = demux_rx_strobe[p] && act[p];
            if (!act[p]) begin
                // idle ports rest at ones, bits ignored
                st_d.rx_dat[p] = 1'b1;                          // R7 R8
            end else if (rx_fill[p]) begin
                // unframed all ones, every bit time
                st_d.rx_dat[p] = 1'b1;                          // R1 R4
            end else if (demux_rx_strobe[p]) begin
                st_d.rx_dat[p] = demux_rx_data[p];
            end
            // transmit lane: loop takes rx data and timing
            if (!act[p]) begin
                st_d.tx_stb[p] = 1'b0;
                st_d.tx_dat[p] = 1'b1;                          // R11
            end else if (loop_on[p]) begin
                // tx pins ignored; raw demux data loops back
                st_d.tx_stb[p] = demux_rx_strobe[p];            // R13 R14
                if (tx_fill[p]) begin
                    st_d.tx_dat[p] = 1'b1;                      // R9
                end else if (demux_rx_strobe[p]) begin
                    st_d.tx_dat[p] = demux_rx_data[p];          // R13 R14
                end
            end else begin
                st_d.tx_stb[p] = tributary_tx_clock_in[p];
                if (tx_fill[p]) begin
                    st_d.tx_dat[p] = 1'b1;                      // R1 R9
                end else if (tributary_tx_clock_in[p]) begin
                    st_d.tx_dat[p] = tributary_tx_data_in[p];
                end
            end
        end
    end

    // state register; reset leaves every port filling
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            st_q.rx_lo  <= tal_pkg::RST_LO;                     // R2
            st_q.rx_hi  <= tal_pkg::RST_HI;                     // R2
            st_q.tx_lo  <= tal_pkg::RST_LO;                     // R2
            st_q.tx_hi  <= tal_pkg::RST_HI;                     // R2
            st_q.ll_lo  <= tal_pkg::RST_LO;                     // R16
            st_q.ll_hi  <= tal_pkg::RST_HI;                     // R16
            st_q.ctrl   <= tal_pkg::RST_CTRL;
            st_q.rdata  <= '0;
            st_q.rx_dat <= '1;
            st_q.rx_stb <= '0;
            st_q.tx_dat <= '1;
            st_q.tx_stb <= '0;
            st_q.rx_fst <= '1;
            st_q.tx_fst <= '1;
        end else begin
            st_q <= st_d;
        end
    end

    // outputs straight from flops
    assign tributary_rx_data_out  = st_q.rx_dat;
    assign tributary_rx_clock_out = st_q.rx_stb;
    assign mux_tx_data            = st_q.tx_dat;
    assign mux_tx_strobe          = st_q.tx_stb;

endmodule : tal_top
`default_nettype wire

// file: verif/tal_trib_model.sv
// tributary line model that clocks one transmit bit into every port
`timescale 1ns/1ps
`default_nettype none
module tal_trib_model (
    input  wire logic        clk,      // clock
    input  wire logic        go,       // send a bit next cycle
    input  wire logic [27:0] bits,     // bits to send
    output logic      [27:0] tx_clock, // one-cycle enable
    output logic      [27:0] tx_data   // line data
);
    initial tx_clock = '0;
    initial tx_data = '0;
    // idle line toggles every cycle so stale data never passes for a bit
    always @(posedge clk) begin
        tx_clock <= go ? 28'hfffffff : 28'h0;
        tx_data  <= go ? bits : ~tx_data;
    end
endmodule // tal_trib_model
`default_nettype wire

// file: verif/tal_top_checker.sv
// port assertions for the tributary fill and loopback block
`timescale 1ns/1ps
`default_nettype none
module tal_top_checker (
    input wire logic        clk,                    // clock
    input wire logic        sys_rst,                // reset
    input wire logic [11:0] paddr,                  // apb address
    input wire logic        psel,                   // select
    input wire logic        penable,                // access
    input wire logic        pwrite,                 // direction
    input wire logic [31:0] prdata,                 // read data
    input wire logic        pready,                 // ready
    input wire logic        pslverr,                // error
    input wire logic [27:0] demux_rx_data,          // rx bit
    input wire logic [27:0] demux_rx_strobe,        // rx strobe
    input wire logic [27:0] tributary_rx_data_out,  // rx out
    input wire logic [27:0] tributary_rx_clock_out, // rx clock
    input wire logic [27:0] tributary_tx_data_in,   // tx in
    input wire logic [27:0] tributary_tx_clock_in,  // tx clock
    input wire logic [27:0] mux_tx_data,            // to mux
    input wire logic [27:0] mux_tx_strobe           // to mux
);
    logic map; // address hits a register
    always_comb map = paddr inside {12'h100, 12'h108, 12'h110, 12'h118, 12'h120,
                                    12'h130, 12'h138, 12'h140, 12'h148};
    default clocking cb @(posedge clk); endclocking
    default disable iff (sys_rst);
    // a read transfer starts with its setup cycle
    sequence s_rd_setup;
        psel && !penable && !pwrite;
    endsequence
    a_reset_fills_ones: assert property ($past(sys_rst) |-> &tributary_rx_data_out
        && &mux_tx_data && tributary_rx_clock_out == 28'h0 && mux_tx_strobe == 28'h0)
        else $error("outputs not idle after reset");
    a_rx_clock_cause: assert property ((tributary_rx_clock_out
        & ~$past(demux_rx_strobe)) == 28'h0) else $error("rx clock without strobe");
    a_tx_clock_cause: assert property ((mux_tx_strobe
        & ~$past(tributary_tx_clock_in | demux_rx_strobe)) == 28'h0)
        else $error("tx strobe without cause");
    a_rx_one_kept: assert property ((~tributary_rx_data_out & $past(demux_rx_strobe)
        & $past(demux_rx_data)) == 28'h0) else $error("rx one lost");
    a_tx_one_kept: assert property ((~mux_tx_data & $past(tributary_tx_clock_in
        & demux_rx_strobe & tributary_tx_data_in & demux_rx_data)) == 28'h0)
        else $error("tx one lost");
    a_high_upper_zero: assert property (s_rd_setup ##1 (psel && penable
        && (paddr == 12'h108 || paddr == 12'h118)) |-> prdata[31:12] == 20'h0)
        else $error("unused high bits read set");
    a_unmapped_read: assert property (s_rd_setup ##1 (psel && penable && !map)
        |-> pslverr && prdata == 32'h0) else $error("unmapped read not refused");
    a_mapped_no_err: assert property (!(psel && penable && map) || !pslverr)
        else $error("error on mapped access");
    a_ready_held: assert property (pready) else $error("ready low");
endmodule // tal_top_checker
bind tal_top tal_top_checker chk_u (.clk(clk), .sys_rst(sys_rst), .paddr(paddr),
    .psel(psel), .penable(penable), .pwrite(pwrite), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .demux_rx_data(demux_rx_data), .demux_rx_strobe(demux_rx_strobe),
    .tributary_rx_data_out(tributary_rx_data_out),
    .tributary_rx_clock_out(tributary_rx_clock_out),
    .tributary_tx_data_in(tributary_tx_data_in),
    .tributary_tx_clock_in(tributary_tx_clock_in), .mux_tx_data(mux_tx_data),
    .mux_tx_strobe(mux_tx_strobe));
`default_nettype wire

// file: verif/tal_top_tb.sv
// self-checking bench for the tributary fill and loopback block
`timescale 1ns/1ps
`default_nettype none
module tal_top_tb;
    logic        clk = 0;                  // 40 MHz clock
    logic        sys_rst = 1;              // sync reset
    logic        psel = 0;                 // apb select
    logic        penable = 0;              // apb access
    logic        pwrite = 0;               // apb direction
    logic [11:0] paddr = '0;               // apb address
    logic [31:0] pwdata = '0;              // apb write data
    logic [31:0] prdata;                   // apb read data
    logic        pready;                   // apb ready
    logic        pslverr;                  // apb error
    logic [27:0] rx_d = '0;                // demux rx bits
    logic [27:0] rx_s = '0;                // demux rx strobes
    logic [27:0] rx_o, rx_c, tx_d, tx_c;   // rx outputs, line inputs
    logic [27:0] mx_d, mx_s;               // mux side outputs
    logic        go = 0;                   // line model request
    logic [27:0] go_bits = '0;             // line model bits
    logic [27:0] rf, tf, ll;               // expected pass and loop bits
    logic [2:0]  ct;                       // expected control
    int          n_errors = 0;             // mismatches
    int          comparisons = 0;          // compares made
    tal_top dut_u (.clk(clk), .sys_rst(sys_rst), .paddr(paddr), .psel(psel),
        .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .demux_rx_data(rx_d), .demux_rx_strobe(rx_s),
        .tributary_rx_data_out(rx_o), .tributary_rx_clock_out(rx_c),
        .tributary_tx_data_in(tx_d), .tributary_tx_clock_in(tx_c), .mux_tx_data(mx_d),
        .mux_tx_strobe(mx_s));
    tal_trib_model line_u (.clk(clk), .go(go), .bits(go_bits), .tx_clock(tx_c),
        .tx_data(tx_d));
    initial forever #12.5 clk = ~clk;
    task automatic test_done;
        $display("errors %0d comparisons %0d", n_errors, comparisons);
        if (n_errors == 0 && comparisons > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask
    task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp) begin
            n_errors++;
            $display("unexpected at %0t: got %h want %h", $time, got, exp);
        end
    endtask
    // one apb transfer; holds the request until ready is seen at an edge
    task automatic apb(input logic [11:0] idx, input logic wr, input logic [31:0] wd,
                       output logic [31:0] rd, output logic err);
        int n;
        n = 0;
        paddr <= {idx[9:0], 2'b00};
        pwrite <= wr;
        pwdata <= wd;
        psel <= 1'b1;
        @(posedge clk);
        penable <= 1'b1;
        do begin
            @(posedge clk);
            n++;
        end while (pready !== 1'b1 && n < 16);
        if (n >= 16) n_errors++;
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        // one idle edge so a following call never reassigns psel in this step
        @(posedge clk);
    endtask
    task automatic wr(input logic [11:0] idx, input logic [31:0] d);
        logic [31:0] r;
        logic e;
        apb(idx, 1'b1, d, r, e);
    endtask
    task automatic rd(input logic [11:0] idx, input logic [31:0] exp, input logic ee);
        logic [31:0] r;
        logic e;
        apb(idx, 1'b0, 32'h0, r, e);
        cmp(r, exp);
        cmp({31'h0, e}, {31'h0, ee});
    endtask
    task automatic cfg(input logic [15:0] rl, input logic [11:0] rh, input logic [15:0] tl,
                       input logic [11:0] th, input logic [2:0] c, input logic [27:0] lw);
        wr(tal_pkg::IDX_RX_LO, {16'h0, rl});
        wr(tal_pkg::IDX_RX_HI, {20'h0, rh});
        wr(tal_pkg::IDX_TX_LO, {16'h0, tl});
        wr(tal_pkg::IDX_TX_HI, {20'h0, th});
        wr(tal_pkg::IDX_CTRL, {29'h0, c});
        wr(tal_pkg::IDX_LL_LO, {16'h0, lw[15:0]});
        wr(tal_pkg::IDX_LL_HI, {20'h0, lw[27:16]});
        rf = {rh, rl};
        tf = {th, tl};
        ct = c;
        ll = lw;
    endtask
    // active ports: g747 drops every fourth port and 22 upward, e3 keeps 1 to 16
    function automatic logic [27:0] act(input logic [2:0] c);
        act = c[1] ? 28'h000ffff : 28'hfffffff;
        if (c[2]) act = 28'h0177777;
    endfunction
    // one bit on every port both ways, then outputs judged a cycle later
    task automatic push(input logic [27:0] rv, input logic [27:0] tv);
        logic [27:0] a;
        logic [27:0] src;
        a = act(ct);
        src = (ll & rv) | (~ll & tv);
        go <= 1'b1;
        go_bits <= tv;
        @(posedge clk);
        go <= 1'b0;
        rx_d <= rv;
        rx_s <= 28'hfffffff;
        @(posedge clk);
        rx_s <= 28'h0;
        rx_d <= ~rv;
        #1;
        cmp({4'h0, rx_o}, {4'h0, ~a | ~(ct[0] ? 28'hfffffff : rf) | rv});
        cmp({4'h0, mx_d}, {4'h0, ~a | ~(ct[0] ? 28'hfffffff : tf) | src});
        cmp({rx_c, 4'h0}, {a, 4'h0});
        cmp({mx_s, 4'h0}, {a, 4'h0});
        @(posedge clk);
    endtask
    task automatic t_reset;
        logic [11:0] r [6] = '{12'h040, 12'h042, 12'h044, 12'h046, 12'h050, 12'h052};
        {rf, tf, ll, ct} = '0;
        for (int i = 0; i < 6; i++) rd(r[i], 32'h0, 1'b0);
        rd(tal_pkg::IDX_RXST, 32'h0fffffff, 1'b0);
        rd(tal_pkg::IDX_TXST, 32'h0fffffff, 1'b0);
        push(28'h0, 28'h0);
        $display("reset test done");
    endtask
    task automatic t_map;
        cfg(16'hfffe, 12'hffe, 16'h7fff, 12'h7ff, 3'h0, 28'h0);
        push(28'h0, 28'h0);
        wr(tal_pkg::IDX_TX_HI, 32'hffffffff);
        rd(tal_pkg::IDX_TX_HI, 32'h00000fff, 1'b0);
        tf[27:16] = 12'hfff;
        push(28'h0, 28'h0);
        rd(12'h3f0, 32'h0, 1'b1);
        $display("mapping test done");
    endtask
    task automatic t_modes;
        logic [2:0] m [4] = '{3'h2, 3'h4, 3'h6, 3'h1};
        logic [15:0] f;
        for (int i = 0; i < 4; i++) begin
            f = (m[i] == 3'h1) ? 16'h0 : 16'hffff;
            cfg(f, f[11:0], f, f[11:0], m[i], 28'h0);
            push(28'h0, 28'h0);
        end
        $display("mode test done");
    endtask
    task automatic t_loop;
        logic [2:0] m [3] = '{3'h0, 3'h4, 3'h2};
        for (int i = 0; i < 3; i++) begin
            cfg(16'hffff, 12'hfff, 16'hfffe, 12'hfff, m[i], 28'h0090009);
            push(28'h0, 28'hfffffff);
        end
        $display("loopback test done");
    endtask
    initial begin
        repeat (20000) @(posedge clk);
        n_errors++;
        test_done();
    end
    initial begin
        repeat (2) @(posedge clk);
        sys_rst <= 1'b0;
        t_reset();
        t_map();
        t_modes();
        t_loop();
        test_done();
    end
endmodule // tal_top_tb
`default_nettype wire
